/* File: src/pdeo_pkg.sv */
// constants shared by the port d/e override block
package pdeo_pkg;
    // port width and lcd mask field width
    localparam int          PIN_CNT    = 8;
    localparam int          LCD_PM_W   = 3;
    // lcd mask thresholds per pin pair (pair used while mask > value)
    localparam logic [2:0]  LCD_THR_76 = 3'h1;
    localparam logic [2:0]  LCD_THR_54 = 3'h2;
    localparam logic [2:0]  LCD_THR_32 = 3'h3;
    localparam logic [2:0]  LCD_THR_10 = 3'h4;
    // pin positions of the alternate functions
    localparam int          PIN_DIVIDED_CLOCK_PIN   = 7;
    localparam int          PIN_SDO    = 6;
    localparam int          PIN_SDA    = 5;
    localparam int          PIN_SCL    = 4;
    localparam int          PIN_XCK    = 2;
    localparam int          PIN_RXD    = 0;
    localparam int          PIN_EXT0   = 1;
    localparam int          PIN_CAPT   = 0;
    // reset values of the registered pin controls
    localparam logic [7:0]  RST_PU     = 8'h00;
    localparam logic [7:0]  RST_OE     = 8'h00;
    localparam logic [7:0]  RST_OUT    = 8'h00;
    localparam logic [7:0]  RST_IE     = 8'h00;
    localparam logic [7:0]  RST_SYNC   = 8'h00;
    localparam logic        RST_BIT    = 1'b0;
    // divided clock: cycles per half period of the output clock
    localparam int          DIVIDED_CLOCK_PIN_HALF  = 1;
    localparam int          DIVIDED_CLOCK_PIN_CNT_W = 8;
endpackage : pdeo_pkg

/* File: src/pdeo_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pdeo_sync
    import pdeo_pkg::*;
#(
    parameter int WIDTH = PIN_CNT
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             SYS_RST_I,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            stage1 <= RST_SYNC[WIDTH-1:0];
            sync_o <= RST_SYNC[WIDTH-1:0];
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : pdeo_sync
`default_nettype wire

/* File: src/pdeo_clkdiv.sv */
// divided clock generator that may keep running through reset
`timescale 1ns/100ps
`default_nettype none
module pdeo_clkdiv
    import pdeo_pkg::*;
#(
    parameter int HALF = DIVIDED_CLOCK_PIN_HALF
) (
    input  wire logic REF_CLK_I,
    input  wire logic SYS_RST_I,
    input  wire logic keep_run_i,
    output logic      tick_o,
    output logic      level_o
);
    localparam logic [DIVIDED_CLOCK_PIN_CNT_W-1:0] LAST = DIVIDED_CLOCK_PIN_CNT_W'(HALF - 1);
    logic [DIVIDED_CLOCK_PIN_CNT_W-1:0] cnt;
    logic                  hold;

    // reset stops the divider only while it is not needed on the pin
    assign hold = SYS_RST_I && !keep_run_i;

    // half period counter, one-cycle tick at its end
    always_ff @(posedge REF_CLK_I) begin
        if (hold) begin
            cnt    <= '0;
            tick_o <= RST_BIT;
        end else if (cnt == LAST) begin
            cnt    <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end

    // output clock level flips on each tick
    always_ff @(posedge REF_CLK_I) begin
        if (hold) begin
            level_o <= RST_BIT;
        end else if (tick_o) begin
            level_o <= ~level_o;
        end
    end
endmodule : pdeo_clkdiv
`default_nettype wire

/* File: src/pdeo_top.sv */
// pin override logic for the two general-purpose ports d and e
//
// Function
// - lcd on and mask above 1: D7, D6 lose pull-up, output drive, input
// - lcd on and mask above 2: D5, D4 forced the same way
// - lcd on and mask above 3: D3, D2 forced the same way
// - lcd on and mask above 4: D0 fully forced; D1 pull-up and direction forced off
// - D1 input enable taken by lcd or ext_a; value is their AND
// - D0 digital input drives timer 1 capture input
// - clock fuse set: E7 driven as output with divided clock
// - clock fuse set: divided clock stays on E7 during reset
// - three-wire mode: E6 output carries serial data output
// - two-wire: E5 pull-up off, open-drain direction, output low
// - two-wire: E4 pull-up off, clock-hold direction, output low, toggle
// - E5, E4 input enabled by pin-change mask or start irq enable
// - port e pin-change pins keep input enabled when masked in
// - E2 direction bit picks usart clock output or input
// - E2 is usart clock only in synchronous mode
// - receiver enabled: E0 forced to input
// - receiver enabled: E0 pull-up follows port bit unless disabled
`timescale 1ns/100ps
`default_nettype none
module pdeo_top
    import pdeo_pkg::*;
(
    input  wire logic                REF_CLK_I,
    input  wire logic                SYS_RST_I,
    input  wire logic [7:0]          PORT_D_I,
    input  wire logic [7:0]          DIR_D_I,
    input  wire logic [7:0]          PORT_E_I,
    input  wire logic [7:0]          DIR_E_I,
    input  wire logic                PULLUP_DISABLE_I,
    input  wire logic                LCD_ENABLE_I,
    input  wire logic [LCD_PM_W-1:0] LCD_PORT_MASK_I,
    input  wire logic                EXT_A_I,
    input  wire logic                CLOCK_OUT_FUSE_I,
    input  wire logic                SERIF_TWO_WIRE_MODE_I,
    input  wire logic                SERIF_THREE_WIRE_MODE_I,
    input  wire logic                SERIF_DATA_OUT_I,
    input  wire logic                CLOCK_HOLD_I,
    input  wire logic                CLOCK_TOGGLE_STROBE_I,
    input  wire logic                START_COND_IRQ_ENABLE_I,
    input  wire logic                PIN_CHANGE_GROUP0_ENABLE_I,
    input  wire logic [7:0]          PIN_CHANGE_MASK_I,
    input  wire logic                USART_SYNC_MODE_I,
    input  wire logic                USART_EXT_CLOCK_OUT_I,
    input  wire logic                USART_RX_ENABLE_I,
    input  wire logic [7:0]          PD_PIN_I,
    input  wire logic [7:0]          PE_PIN_I,
    output logic      [7:0]          PD_PULLUP_O,
    output logic      [7:0]          PD_OE_O,
    output logic      [7:0]          PD_OUT_O,
    output logic      [7:0]          PD_IE_O,
    output logic      [7:0]          PE_PULLUP_O,
    output logic      [7:0]          PE_OE_O,
    output logic      [7:0]          PE_OUT_O,
    output logic      [7:0]          PE_IE_O,
    output logic                     EXT_A_IN_O,
    output logic                     TIMER1_CAPTURE_INPUT_O,
    output logic      [7:0]          PIN_CHANGE_IN_O,
    output logic                     SERIF_DATA_IN_O,
    output logic                     SERIF_CLOCK_IN_O,
    output logic                     USART_RX_IN_O,
    output logic                     USART_EXT_CLOCK_IN_O
);
    // override enables and values per pin
    logic [7:0] d_pu_en, d_pu_val, d_dir_en, d_dir_val;
    logic [7:0] d_out_en, d_out_val, d_ie_en, d_ie_val;
    logic [7:0] e_pu_en, e_pu_val, e_dir_en, e_dir_val;
    logic [7:0] e_out_en, e_out_val, e_ie_en, e_ie_val;
    logic [7:0] e_tog_en;
    // resolved controls before the output flops
    logic [7:0] next_pd_pu, next_pd_oe, next_pd_out, next_pd_ie;
    logic [7:0] next_pe_pu, next_pe_oe, next_pe_out, next_pe_ie;
    logic [7:0] pd_sync, pe_sync, pc_hit;
    logic       divided_clock_pin_tick, divided_clock_pin_level, scl_tog;
    logic       lcd_76, lcd_54, lcd_32, lcd_10;

    // replace the port control where the override is active
    function automatic logic [7:0] resolve(input logic [7:0] en,
                                           input logic [7:0] val,
                                           input logic [7:0] base);
        resolve = (en & val) | (~en & base);
    endfunction : resolve

    // lcd takes a pin pair while enabled and the mask is above a threshold
    function automatic logic lcd_take(input logic [LCD_PM_W-1:0] pm,
                                      input logic [LCD_PM_W-1:0] thr);
        lcd_take = LCD_ENABLE_I && (pm > thr);
    endfunction : lcd_take

    // pin inputs come from outside the clock domain
    pdeo_sync #(.WIDTH(PIN_CNT)) u_sync_d (
        .REF_CLK_I (REF_CLK_I),
        .SYS_RST_I (SYS_RST_I),
        .async_i   (PD_PIN_I),
        .sync_o    (pd_sync)
    );
    pdeo_sync #(.WIDTH(PIN_CNT)) u_sync_e (
        .REF_CLK_I (REF_CLK_I),
        .SYS_RST_I (SYS_RST_I),
        .async_i   (PE_PIN_I),
        .sync_o    (pe_sync)
    );

    // divided system clock, kept alive through reset by the fuse
    pdeo_clkdiv #(.HALF(DIVIDED_CLOCK_PIN_HALF)) u_clkdiv (
        .REF_CLK_I  (REF_CLK_I),
        .SYS_RST_I  (SYS_RST_I),
        .keep_run_i (CLOCK_OUT_FUSE_I),
        .tick_o     (divided_clock_pin_tick),
        .level_o    (divided_clock_pin_level)
    );

    // serial clock toggle state applied to E4 port value
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            scl_tog <= RST_BIT;
        end else if (e_tog_en[PIN_SCL]) begin
            scl_tog <= ~scl_tog;
        end
    end

    // port d: lcd segments, external interrupt and capture pin
    always_comb begin
        lcd_76    = lcd_take(LCD_PORT_MASK_I, LCD_THR_76);
        lcd_54    = lcd_take(LCD_PORT_MASK_I, LCD_THR_54);
        lcd_32    = lcd_take(LCD_PORT_MASK_I, LCD_THR_32);
        lcd_10    = lcd_take(LCD_PORT_MASK_I, LCD_THR_10);
        d_pu_en   = {{2{lcd_76}}, {2{lcd_54}}, {2{lcd_32}}, {2{lcd_10}}};
        d_dir_en  = d_pu_en;
        d_ie_en   = d_pu_en;
        d_pu_val  = 8'h00;
        d_dir_val = 8'h00;
        d_out_en  = 8'h00;
        d_out_val = 8'h00;
        d_ie_val  = 8'h00;
        d_ie_en[PIN_EXT0]  = LCD_ENABLE_I || EXT_A_I;
        d_ie_val[PIN_EXT0] = LCD_ENABLE_I && EXT_A_I;
    end

    // port e: pin change, clock out, serial interface, usart
    always_comb begin
        pc_hit    = PIN_CHANGE_MASK_I & {8{PIN_CHANGE_GROUP0_ENABLE_I}};
        e_pu_en   = 8'h00;
        e_pu_val  = 8'h00;
        e_dir_en  = 8'h00;
        e_dir_val = 8'h00;
        e_out_en  = 8'h00;
        e_out_val = 8'h00;
        e_tog_en  = 8'h00;
        e_ie_en   = pc_hit;
        e_ie_val  = 8'hff;
        // divided clock drives E7 regardless of port and direction
        e_dir_en[PIN_DIVIDED_CLOCK_PIN]  = CLOCK_OUT_FUSE_I;
        e_dir_val[PIN_DIVIDED_CLOCK_PIN] = 1'b1;
        e_out_en[PIN_DIVIDED_CLOCK_PIN]  = CLOCK_OUT_FUSE_I;
        e_out_val[PIN_DIVIDED_CLOCK_PIN] = divided_clock_pin_level;
        // three-wire data output
        e_out_en[PIN_SDO]   = SERIF_THREE_WIRE_MODE_I;
        e_out_val[PIN_SDO]  = SERIF_DATA_OUT_I;
        // two-wire data line, open drain by direction
        e_pu_en[PIN_SDA]    = SERIF_TWO_WIRE_MODE_I;
        e_dir_en[PIN_SDA]   = SERIF_TWO_WIRE_MODE_I;
        e_dir_val[PIN_SDA]  = (~SERIF_DATA_OUT_I | ~PORT_E_I[PIN_SDA])
                              & DIR_E_I[PIN_SDA];
        e_out_en[PIN_SDA]   = SERIF_TWO_WIRE_MODE_I & DIR_E_I[PIN_SDA];
        // two-wire clock line with hold and toggle
        e_pu_en[PIN_SCL]    = SERIF_TWO_WIRE_MODE_I;
        e_dir_en[PIN_SCL]   = SERIF_TWO_WIRE_MODE_I;
        e_dir_val[PIN_SCL]  = (CLOCK_HOLD_I & ~PORT_E_I[PIN_SCL])
                              | DIR_E_I[PIN_SCL];
        e_out_en[PIN_SCL]   = SERIF_TWO_WIRE_MODE_I & DIR_E_I[PIN_SCL];
        e_tog_en[PIN_SCL]   = CLOCK_TOGGLE_STROBE_I;
        // start condition detector needs both two-wire inputs
        e_ie_en[PIN_SDA]    = pc_hit[PIN_SDA]
                              | START_COND_IRQ_ENABLE_I;
        e_ie_en[PIN_SCL]    = pc_hit[PIN_SCL]
                              | START_COND_IRQ_ENABLE_I;
        // usart clock drives only in synchronous mode with direction set
        e_out_en[PIN_XCK]   = USART_SYNC_MODE_I & DIR_E_I[PIN_XCK];
        e_out_val[PIN_XCK]  = USART_EXT_CLOCK_OUT_I;
        // receiver forces input, pull-up from port bit
        e_pu_en[PIN_RXD]    = USART_RX_ENABLE_I;
        e_pu_val[PIN_RXD]   = PORT_E_I[PIN_RXD] & ~PULLUP_DISABLE_I;
        e_dir_en[PIN_RXD]   = USART_RX_ENABLE_I;
        e_dir_val[PIN_RXD]  = 1'b0;
    end

    // resolve overrides against port registers
    always_comb begin
        next_pd_pu  = resolve(d_pu_en, d_pu_val,
                              PORT_D_I & ~DIR_D_I & {8{~PULLUP_DISABLE_I}});
        next_pd_oe  = resolve(d_dir_en, d_dir_val, DIR_D_I);
        next_pd_out = resolve(d_out_en, d_out_val, PORT_D_I);
        next_pd_ie  = resolve(d_ie_en, d_ie_val, 8'hff);
        next_pe_pu  = resolve(e_pu_en, e_pu_val,
                              PORT_E_I & ~DIR_E_I & {8{~PULLUP_DISABLE_I}});
        next_pe_oe  = resolve(e_dir_en, e_dir_val, DIR_E_I);
        next_pe_out = resolve(e_out_en, e_out_val,
                              PORT_E_I ^ {3'h0, scl_tog, 4'h0});
        next_pe_ie  = resolve(e_ie_en, e_ie_val, 8'hff);
    end

    // port d pin control flops
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            PD_PULLUP_O <= RST_PU;
            PD_OE_O     <= RST_OE;
            PD_OUT_O    <= RST_OUT;
            PD_IE_O     <= RST_IE;
        end else begin
            PD_PULLUP_O <= next_pd_pu;
            PD_OE_O     <= next_pd_oe;
            PD_OUT_O    <= next_pd_out;
            PD_IE_O     <= next_pd_ie;
        end
    end

    // port e pin control flops, E7 keeps the clock during reset
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            PE_PULLUP_O <= RST_PU;
            PE_OE_O     <= RST_OE | {CLOCK_OUT_FUSE_I, 7'h00};
            PE_OUT_O    <= RST_OUT
                           | {CLOCK_OUT_FUSE_I & divided_clock_pin_level, 7'h00};
        end else begin
            PE_PULLUP_O <= next_pe_pu;
            PE_OE_O     <= next_pe_oe;
            PE_OUT_O    <= next_pe_out;
        end
    end

    // port e input enable flop
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            PE_IE_O <= RST_IE;
        end else begin
            PE_IE_O <= next_pe_ie;
        end
    end

    // digital inputs routed to the peripherals
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            EXT_A_IN_O             <= RST_BIT;
            TIMER1_CAPTURE_INPUT_O <= RST_BIT;
            PIN_CHANGE_IN_O        <= RST_SYNC;
            SERIF_DATA_IN_O        <= RST_BIT;
            SERIF_CLOCK_IN_O       <= RST_BIT;
            USART_RX_IN_O          <= RST_BIT;
            USART_EXT_CLOCK_IN_O   <= RST_BIT;
        end else begin
            EXT_A_IN_O  <= pd_sync[PIN_EXT0] & next_pd_ie[PIN_EXT0];
            TIMER1_CAPTURE_INPUT_O <= pd_sync[PIN_CAPT]
                                      & next_pd_ie[PIN_CAPT];
            PIN_CHANGE_IN_O  <= pe_sync & next_pe_ie;
            SERIF_DATA_IN_O  <= pe_sync[PIN_SDA] & next_pe_ie[PIN_SDA];
            SERIF_CLOCK_IN_O <= pe_sync[PIN_SCL] & next_pe_ie[PIN_SCL];
            USART_RX_IN_O    <= pe_sync[PIN_RXD] & next_pe_ie[PIN_RXD];
            USART_EXT_CLOCK_IN_O <= pe_sync[PIN_XCK] & USART_SYNC_MODE_I
                                    & ~DIR_E_I[PIN_XCK];
        end
    end

    // checks next to the logic
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_rst_fuse;
        SYS_RST_I && CLOCK_OUT_FUSE_I;
    endsequence
    sequence s_rst_fuse_held;
        s_rst_fuse ##1 s_rst_fuse;
    endsequence

    AST_LCD_PAIR76: assert property (
        lcd_take(LCD_PORT_MASK_I, LCD_THR_76) |=>
        (PD_OE_O[7:6] == 2'h0) && (PD_PULLUP_O[7:6] == 2'h0)
        && (PD_IE_O[7:6] == 2'h0))
        else $error("lcd did not take D7 D6");
    AST_LCD_PAIR54: assert property (
        lcd_take(LCD_PORT_MASK_I, LCD_THR_54) |=>
        (PD_OE_O[5:4] == 2'h0) && (PD_IE_O[5:4] == 2'h0)
        && (PD_PULLUP_O[5:4] == 2'h0))
        else $error("lcd did not take D5 D4");
    AST_LCD_PAIR32: assert property (
        lcd_take(LCD_PORT_MASK_I, LCD_THR_32) |=>
        (PD_OE_O[3:2] == 2'h0) && (PD_PULLUP_O[3:2] == 2'h0)
        && (PD_IE_O[3:2] == 2'h0))
        else $error("lcd did not take D3 D2");
    AST_LCD_PAIR10: assert property (
        lcd_take(LCD_PORT_MASK_I, LCD_THR_10) |=>
        (PD_OE_O[1:0] == 2'h0) && !PD_IE_O[0] && !PD_PULLUP_O[1])
        else $error("lcd did not take D1 D0");
    AST_LCD_MASK_LOW: assert property (
        (LCD_PORT_MASK_I == 3'h1) && !EXT_A_I |=>
        PD_OE_O[7] == $past(DIR_D_I[7]))
        else $error("D7 taken with mask at threshold");
    AST_EXT_A_IE: assert property (
        (LCD_ENABLE_I || EXT_A_I) |=>
        PD_IE_O[1] == $past(LCD_ENABLE_I && EXT_A_I))
        else $error("D1 input enable value wrong");
    AST_CAPTURE: assert property (
        !lcd_10 && pd_sync[0] |=> TIMER1_CAPTURE_INPUT_O)
        else $error("capture input not routed from D0");
    AST_DIVIDED_CLOCK_PIN_DRIVE: assert property (
        CLOCK_OUT_FUSE_I |=> PE_OE_O[7] && PE_OUT_O[7] == $past(divided_clock_pin_level))
        else $error("divided clock not on E7");
    AST_DIVIDED_CLOCK_PIN_RESET: assert property (
        disable iff (1'b0)
        s_rst_fuse_held |=> PE_OE_O[7] && PE_OUT_O[7] != $past(PE_OUT_O[7]))
        else $error("divided clock stopped in reset");
    AST_SDO: assert property (
        SERIF_THREE_WIRE_MODE_I |=> PE_OUT_O[6] == $past(SERIF_DATA_OUT_I))
        else $error("E6 does not carry serial data");
    AST_SDA: assert property (
        SERIF_TWO_WIRE_MODE_I && DIR_E_I[5] |=> !PE_OUT_O[5]
        && !PE_PULLUP_O[5]
        && PE_OE_O[5] == $past(~SERIF_DATA_OUT_I | ~PORT_E_I[5]))
        else $error("E5 two-wire override wrong");
    AST_SCL: assert property (
        SERIF_TWO_WIRE_MODE_I |=> !PE_PULLUP_O[4] && PE_OE_O[4] ==
        $past((CLOCK_HOLD_I & ~PORT_E_I[4]) | DIR_E_I[4]))
        else $error("E4 two-wire direction wrong");
    AST_START_IE: assert property (
        START_COND_IRQ_ENABLE_I |=> PE_IE_O[5] && PE_IE_O[4])
        else $error("start detector inputs disabled");
    AST_PC_IE: assert property (
        PIN_CHANGE_GROUP0_ENABLE_I && PIN_CHANGE_MASK_I[7] |=> PE_IE_O[7])
        else $error("pin change input disabled");
    AST_XCK: assert property (
        !USART_SYNC_MODE_I |=> PE_OUT_O[2] == $past(PORT_E_I[2])
        && PE_OE_O[2] == $past(DIR_E_I[2]) && !USART_EXT_CLOCK_IN_O)
        else $error("E2 not plain outside synchronous mode");
    AST_XCK_DRIVE: assert property (
        USART_SYNC_MODE_I && DIR_E_I[2] |=> PE_OE_O[2]
        && PE_OUT_O[2] == $past(USART_EXT_CLOCK_OUT_I))
        else $error("E2 does not drive the usart clock");
    AST_RXD: assert property (
        USART_RX_ENABLE_I |=> !PE_OE_O[0]
        && PE_PULLUP_O[0] == $past(PORT_E_I[0] & ~PULLUP_DISABLE_I))
        else $error("E0 receiver override wrong");
endmodule : pdeo_top
`default_nettype wire

/* File: sim/pdeo_pin_model.sv */
// pad model: resolves pin levels from drive, pull-up and outside source
`timescale 1ns/100ps
`default_nettype none
module pdeo_pin_model (
    input  wire logic [7:0] pd_oe_i,
    input  wire logic [7:0] pd_out_i,
    input  wire logic [7:0] pd_pu_i,
    input  wire logic [7:0] pe_oe_i,
    input  wire logic [7:0] pe_out_i,
    input  wire logic [7:0] pe_pu_i,
    input  wire logic [7:0] ext_d_i,
    input  wire logic [7:0] ext_e_i,
    output logic      [7:0] pd_pin_o,
    output logic      [7:0] pe_pin_o
);
    // driven pad shows its output, else pull-up wins over outside level
    assign pd_pin_o = (pd_oe_i & pd_out_i) | (~pd_oe_i & (pd_pu_i | ext_d_i));
    assign pe_pin_o = (pe_oe_i & pe_out_i) | (~pe_oe_i & (pe_pu_i | ext_e_i));
endmodule : pdeo_pin_model
`default_nettype wire

/* File: sim/port_d_e_alt_function_override_tb.sv */
// self-checking bench for the port d/e override block
`timescale 1ns/100ps
`default_nettype none
module port_d_e_alt_function_override_tb;
    import pdeo_pkg::*;
    typedef struct packed {
        logic [7:0] pd, dd, pe, de;
        logic       pud, lcd;
        logic [2:0] msk;
        logic       exta, fuse, two, three, sdo, hold, stb, start, grp;
        logic [7:0] pcm;
        logic       sync, usart_ext_clock, rx;
    } pdeo_in_s;
    typedef struct packed {
        logic [7:0] dpu, doe, dout, die, epu, eoe, eout, eie;
        logic       fuse;
    } pdeo_exp_s;
    logic       clk, rst, tgl, prev;
    pdeo_in_s   ci, c;
    logic [7:0] ext_d, ext_e, pd_pin, pe_pin;
    logic [7:0] dpu, doe, dout, die, epu, eoe, eout, eie, pcin;
    logic       ea_in, cap_in, sd_in, sc_in, rx_in, uc_in;
    logic [63:0] r;
    pdeo_exp_s  q[$];
    pdeo_exp_s  n;
    int         failures, total_checks;
    pdeo_top dut_u (.REF_CLK_I(clk), .SYS_RST_I(rst), .PORT_D_I(ci.pd),
        .DIR_D_I(ci.dd), .PORT_E_I(ci.pe), .DIR_E_I(ci.de),
        .PULLUP_DISABLE_I(ci.pud), .LCD_ENABLE_I(ci.lcd),
        .LCD_PORT_MASK_I(ci.msk), .EXT_A_I(ci.exta),
        .CLOCK_OUT_FUSE_I(ci.fuse), .SERIF_TWO_WIRE_MODE_I(ci.two),
        .SERIF_THREE_WIRE_MODE_I(ci.three), .SERIF_DATA_OUT_I(ci.sdo),
        .CLOCK_HOLD_I(ci.hold), .CLOCK_TOGGLE_STROBE_I(ci.stb),
        .START_COND_IRQ_ENABLE_I(ci.start),
        .PIN_CHANGE_GROUP0_ENABLE_I(ci.grp), .PIN_CHANGE_MASK_I(ci.pcm),
        .USART_SYNC_MODE_I(ci.sync), .USART_EXT_CLOCK_OUT_I(ci.usart_ext_clock),
        .USART_RX_ENABLE_I(ci.rx), .PD_PIN_I(pd_pin), .PE_PIN_I(pe_pin),
        .PD_PULLUP_O(dpu), .PD_OE_O(doe), .PD_OUT_O(dout), .PD_IE_O(die),
        .PE_PULLUP_O(epu), .PE_OE_O(eoe), .PE_OUT_O(eout), .PE_IE_O(eie),
        .EXT_A_IN_O(ea_in), .TIMER1_CAPTURE_INPUT_O(cap_in),
        .PIN_CHANGE_IN_O(pcin), .SERIF_DATA_IN_O(sd_in),
        .SERIF_CLOCK_IN_O(sc_in), .USART_RX_IN_O(rx_in),
        .USART_EXT_CLOCK_IN_O(uc_in));
    pdeo_pin_model pin_u (.pd_oe_i(doe), .pd_out_i(dout), .pd_pu_i(dpu),
        .pe_oe_i(eoe), .pe_out_i(eout), .pe_pu_i(epu), .ext_d_i(ext_d),
        .ext_e_i(ext_e), .pd_pin_o(pd_pin), .pe_pin_o(pe_pin));
    // expected pin controls for one set of inputs
    function automatic pdeo_exp_s model(input pdeo_in_s c, input logic t);
        pdeo_exp_s  e;
        logic [7:0] lm;
        lm = {{2{c.msk > LCD_THR_76}}, {2{c.msk > LCD_THR_54}},
              {2{c.msk > LCD_THR_32}}, {2{c.msk > LCD_THR_10}}} & {8{c.lcd}};
        e.dpu = c.pd & ~c.dd & ~{8{c.pud}} & ~lm;
        e.doe = c.dd & ~lm;
        e.dout = c.pd;
        e.die = ~lm;
        e.die[1] = (c.lcd | c.exta) ? (c.lcd & c.exta) : 1'b1;
        e.epu = c.pe & ~c.de & ~{8{c.pud}};
        e.eoe = c.de;
        e.eout = c.pe ^ {3'h0, t, 4'h0};
        e.eie = 8'hff;
        if (c.fuse) e.eoe[7] = 1'b1;
        if (c.three) e.eout[6] = c.sdo;
        if (c.two) begin
            e.epu[5:4] = 2'h0;
            e.eoe[5] = (~c.sdo | ~c.pe[5]) & c.de[5];
            e.eoe[4] = (c.hold & ~c.pe[4]) | c.de[4];
            if (c.de[5]) e.eout[5] = 1'b0;
            if (c.de[4]) e.eout[4] = 1'b0;
        end
        if (c.sync & c.de[2]) e.eout[2] = c.usart_ext_clock;
        if (c.rx) begin
            e.eoe[0] = 1'b0;
            e.epu[0] = c.pe[0] & ~c.pud;
        end
        e.fuse = c.fuse;
        return e;
    endfunction : model
    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] sn);
        total_checks++;
        if (sn !== ex) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk
    // drive one input set at the falling edge and note its expectation
    task automatic step(input pdeo_in_s s);
        @(negedge clk);
        ci = s;
        q.push_back(model(s, tgl));
        if (s.stb) tgl = ~tgl;
    endtask : step
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // clock generation
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // output watcher: oldest note against registered outputs
    initial forever begin
        @(posedge clk);
        #5;
        if (q.size() > 0) begin
            n = q.pop_front();
            chk("pd_pullup", n.dpu, dpu);
            chk("pd_oe", n.doe, doe);
            chk("pd_out", n.dout, dout);
            chk("pd_ie", n.die, die);
            chk("pe_pullup", n.epu, epu);
            chk("pe_oe", n.eoe, eoe);
            chk("pe_out", n.eout, {n.fuse ? n.eout[7] : eout[7], eout[6:0]});
            chk("pe_ie", n.eie, eie);
        end
    end
    // watchdog
    initial begin
        #100000;
        failures++;
        $display("watchdog expired");
        give_verdict();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        ci = '0;
        tgl = 1'b0;
        ext_d = 8'h00;
        ext_e = 8'h00;
        failures = 0;
        total_checks = 0;
        void'($urandom(77));
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int i = 0; i < 316; i++) begin
            r = {$urandom, $urandom};
            c = r[$bits(pdeo_in_s)-1:0];
            if (i >= 300) begin
                c.lcd = 1'b1;
                c.msk = i[2:0];
                c.exta = i[3];
            end
            step(c);
        end
        repeat (3) @(posedge clk);
        $display("test random controls done");
        for (int j = 0; j < 8; j++) begin
            c = '0;
            c.lcd = j[0];
            c.exta = j[1];
            c.msk = j[2] ? 3'h5 : 3'h4;
            c.sync = j[1] ^ j[2];
            @(negedge clk);
            ci = c;
            ext_d = 8'($urandom);
            ext_e = 8'($urandom);
            repeat (5) @(posedge clk);
            #5;
            chk("pin inputs", {5'h0, ext_d[0] & ~(j[0] & j[2]),
                ext_d[1] & ((j[0] | j[1]) ? (j[0] & j[1]) : 1'b1),
                ci.sync & ext_e[2]}, {5'h0, cap_in, ea_in, uc_in});
            chk("pin change in", ext_e, pcin);
            chk("serial and rx in", {5'h0, ext_e[5], ext_e[4], ext_e[0]},
                {5'h0, sd_in, sc_in, rx_in});
        end
        $display("test pin inputs done");
        c = '0;
        c.fuse = 1'b1;
        @(negedge clk);
        ci = c;
        rst = 1'b1;
        tgl = 1'b0;
        repeat (2) @(posedge clk);
        #5;
        prev = eout[7];
        repeat (4) begin
            @(posedge clk);
            #5;
            chk("divided_clock_pin in reset", {~prev, 7'h0}, eout);
            chk("divided_clock_pin oe in reset", 8'h80, eoe);
            prev = ~prev;
        end
        @(negedge clk) rst = 1'b0;
        $display("test clock out in reset done");
        give_verdict();
    end
endmodule : port_d_e_alt_function_override_tb
`default_nettype wire
